// ### hdl/timer_consts.svh
// Register offsets, field positions, reset values of the timer pair
`ifndef TIMER_CONSTS_SVH
`define TIMER_CONSTS_SVH

// ------------------------------------------------------------------
// Register word offsets (byte addresses)
// ------------------------------------------------------------------
`define OFS_CFG        8'h00
`define OFS_CTL        8'h04
`define OFS_LOAD_A     8'h08
`define OFS_LOAD_B     8'h0C
`define OFS_LOAD_BOTH  8'h10
`define OFS_MATCH_A    8'h14
`define OFS_MATCH_B    8'h18
`define OFS_MATCH_BOTH 8'h1C
`define OFS_PRE_A      8'h20
`define OFS_PRE_B      8'h24
`define OFS_PRE_BOTH   8'h28
`define OFS_PMR_A      8'h2C
`define OFS_PMR_B      8'h30
`define OFS_PMR_BOTH   8'h34
`define OFS_VAL_A      8'h38
`define OFS_VAL_B      8'h3C
`define OFS_IMASK      8'h40
`define OFS_RIS        8'h44
`define OFS_MIS        8'h48
`define OFS_ICLR       8'h4C
`define OFS_STATUS_SEL 8'h50

// ------------------------------------------------------------------
// Interrupt bit positions
// ------------------------------------------------------------------
`define IRQ_A_TIMEOUT   0
`define IRQ_A_CAP_MATCH 1
`define IRQ_A_CAP_EVENT 2
`define IRQ_RTC_MATCH   3
`define IRQ_B_TIMEOUT   8
`define IRQ_B_CAP_MATCH 9
`define IRQ_B_CAP_EVENT 10
`define IRQ_WIDTH       11

// ------------------------------------------------------------------
// Config and control fields
// ------------------------------------------------------------------
`define CFG_JOIN_BIT    0
`define CFG_MODE_A_LSB  4
`define CFG_MODE_B_LSB  8
`define CFG_MODE_W      3
`define CTL_EN_A_BIT    0
`define CTL_EN_B_BIT    1
`define CTL_MIE_A_BIT   2
`define CTL_MIE_B_BIT   3
`define RESET_VALUE     32'h0000_0000

`endif

// ### hdl/timer_pkg.sv
// Types shared by the timer pair
package timer_pkg;
    typedef enum logic [2:0] {
        MODE_ONE_SHOT,
        MODE_PERIODIC,
        MODE_ONE_SHOT_UP,
        MODE_PERIODIC_UP,
        MODE_CAP_COUNT,
        MODE_CAP_COUNT_UP,
        MODE_CAP_TIME,
        MODE_PWM
    } mode_t;
endpackage : timer_pkg

// ### hdl/half_if.sv
// Control and event bundle between the top and one timer half
`timescale 1ns/1ps
interface half_if #(parameter int HW = 32, parameter int PW = 16);
    logic                   en;
    logic                   mie;
    timer_pkg::mode_t       mode;
    logic [HW-1:0]          load;
    logic [HW-1:0]          match;
    logic [PW-1:0]          pre;
    logic [PW-1:0]          pmr;
    logic                   load_now;
    logic                   cap_edge;
    logic [HW+PW-1:0]       value;
    logic                   timeout;
    logic                   cap_match;
    logic                   cap_event;
    logic                   pwm;
    modport top  (output en, mie, mode, load, match, pre, pmr, load_now, cap_edge,
                  input value, timeout, cap_match, cap_event, pwm);
    modport half (input en, mie, mode, load, match, pre, pmr, load_now, cap_edge,
                  output value, timeout, cap_match, cap_event, pwm);
endinterface : half_if

// ### hdl/timer_half.sv
// One half-width timer with prescale extension
`timescale 1ns/1ps
module timer_half #(
    parameter int HW = 32,
    parameter int PW = 16
) (
    input  wire logic MCLK,
    input  wire logic RST_N,
    input  wire logic CE,
    half_if.half      h
);
    localparam int EW = HW + PW;

    logic [EW-1:0] cnt_q;
    logic [EW-1:0] cnt_d;
    logic [EW-1:0] top_val;
    logic [EW-1:0] cmp_val;
    logic          down;
    logic          presc_low;
    logic          capm;
    logic          at_end;
    logic          tick;

    // ------------------------------------------------------------------
    // Extended count layout
    // ------------------------------------------------------------------
    assign down      = (h.mode == timer_pkg::MODE_ONE_SHOT) ||
                       (h.mode == timer_pkg::MODE_PERIODIC) ||
                       (h.mode == timer_pkg::MODE_CAP_COUNT) ||
                       (h.mode == timer_pkg::MODE_CAP_TIME) ||
                       (h.mode == timer_pkg::MODE_PWM);
    assign presc_low = (h.mode == timer_pkg::MODE_ONE_SHOT) ||
                       (h.mode == timer_pkg::MODE_PERIODIC);
    assign top_val   = presc_low ? {h.load, h.pre} : {h.pre, h.load};
    assign cmp_val   = presc_low ? {h.match, h.pmr} : {h.pmr, h.match};
    assign capm      = (h.mode == timer_pkg::MODE_CAP_COUNT) ||
                       (h.mode == timer_pkg::MODE_CAP_COUNT_UP);
    assign tick      = capm ? h.cap_edge : 1'b1;
    assign at_end    = down ? (cnt_q == '0) : (cnt_q == top_val);
    assign cnt_d     = h.load_now ? (down ? top_val : '0) :
                       at_end     ? (down ? top_val : '0) :
                       down       ? cnt_q - EW'(1) : cnt_q + EW'(1);

    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            cnt_q <= '0;
        end else if (CE && (h.load_now || (h.en && tick))) begin
            cnt_q <= cnt_d;
        end
    end

    // ------------------------------------------------------------------
    // Events and output
    // ------------------------------------------------------------------
    logic os_done_q;
    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            os_done_q <= 1'b0;
        end else if (CE) begin
            if (h.load_now) begin
                os_done_q <= 1'b0;
            end else if (h.en && at_end && (h.mode == timer_pkg::MODE_ONE_SHOT ||
                         h.mode == timer_pkg::MODE_ONE_SHOT_UP)) begin
                os_done_q <= 1'b1;
            end
        end
    end

    assign h.value     = cnt_q;
    assign h.timeout   = CE && h.en && !os_done_q && !capm &&
                         (h.mode != timer_pkg::MODE_CAP_TIME) && at_end;
    assign h.cap_match = CE && h.en && ((capm && tick && cnt_q == cmp_val) ||
                         (h.mie && !capm && cnt_q == cmp_val && !os_done_q));
    assign h.cap_event = CE && h.en && h.cap_edge &&
                         (h.mode == timer_pkg::MODE_CAP_TIME ||
                          h.mode == timer_pkg::MODE_PWM);
    assign h.pwm       = (h.mode == timer_pkg::MODE_PWM) && h.en &&
                         (cnt_q > cmp_val);
endmodule : timer_half

// ### hdl/timer_load_match_prescale.sv
// Timer pair: load, match, prescale and interrupt status registers
`timescale 1ns/1ps
`include "timer_consts.svh"
// Behaviour
// - Load write while running reloads the live counter immediately.
// - Joined mode takes a full-width load and applies it immediately.
// - Load value reads back separately from the live count.
// - Prescaler only extends count in half-width mode; ignored when joined.
// - Prescaler is low part counting down periodic/one-shot, else high part.
// - Prescale-match joins match to extend match range in half-width modes.
// - Prescale fields hold 0-255 narrow, 0-65535 wide.
// - Edge-count capture raises capture-match when count equals match.
// - PWM output changes level at the match point each period.
// - Optional match interrupt in periodic and one-shot modes.
// - Raw status shows all pending; masked shows only enabled ones.
// - Raw, masked and enable words share bit positions.
// - Narrow type word-wide in all modes; wide type word-wide in half mode.
// - Sources: capture event, capture match, timeout per half, plus clock match.
// - Only enabled sources drive the interrupt output.
// - Clear write deasserts exactly the selected pending sources.
module timer_load_match_prescale #(
    parameter int HW   = 32,
    parameter int PW   = 16,
    parameter bit WIDE = 1'b1
) (
    input  wire logic        MCLK,
    input  wire logic        RST_N,
    input  wire logic        CE,
    input  wire logic [7:0]  ADDR,
    input  wire logic [31:0] WDATA,
    input  wire logic        WR,
    input  wire logic        RD,
    input  wire logic        CAP_A,
    input  wire logic        CAP_B,
    input  wire logic        RTC_MATCH,
    output logic      [31:0] RDATA,
    output logic             IRQ,
    output logic             PWM_A,
    output logic             PWM_B
);
    localparam int EW  = HW + PW;
    localparam int IW  = `IRQ_WIDTH;
    localparam int PEW = WIDE ? 16 : 8;

    half_if #(.HW(HW), .PW(PW)) ha ();
    half_if #(.HW(HW), .PW(PW)) hb ();

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    logic [2:0] s1_q;
    logic [2:0] s2_q;
    logic [2:0] s3_q;
    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
        end else if (CE) begin
            s1_q <= {RTC_MATCH, CAP_B, CAP_A};
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end
    wire [2:0] rise = s2_q & ~s3_q;

    // ------------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------------
    logic          join_q;
    logic [2:0]    mode_a_q, mode_b_q;
    logic [3:0]    ctl_q;
    logic [HW-1:0] load_a_q, load_b_q, match_a_q, match_b_q;
    logic [PW-1:0] pre_a_q, pre_b_q, pmr_a_q, pmr_b_q;
    logic [IW-1:0] imask_q, ris_q, ris_d, iset;
    logic          sel_q;

    wire w_cfg   = WR && ADDR == `OFS_CFG;
    wire w_ctl   = WR && ADDR == `OFS_CTL;
    wire w_ld_a  = WR && (ADDR == `OFS_LOAD_A || ADDR == `OFS_LOAD_BOTH);
    wire w_ld_b  = WR && (ADDR == `OFS_LOAD_B || ADDR == `OFS_LOAD_BOTH);
    wire w_ld_hi = WR && join_q && ADDR == `OFS_LOAD_B;
    wire w_mt_a  = WR && (ADDR == `OFS_MATCH_A || ADDR == `OFS_MATCH_BOTH);
    wire w_mt_b  = WR && (ADDR == `OFS_MATCH_B || ADDR == `OFS_MATCH_BOTH);
    wire w_pr_a  = WR && (ADDR == `OFS_PRE_A || ADDR == `OFS_PRE_BOTH);
    wire w_pr_b  = WR && (ADDR == `OFS_PRE_B || ADDR == `OFS_PRE_BOTH);
    wire w_pm_a  = WR && (ADDR == `OFS_PMR_A || ADDR == `OFS_PMR_BOTH);
    wire w_pm_b  = WR && (ADDR == `OFS_PMR_B || ADDR == `OFS_PMR_BOTH);
    wire w_imask = WR && ADDR == `OFS_IMASK;
    wire w_iclr  = WR && ADDR == `OFS_ICLR;
    wire w_sel   = WR && ADDR == `OFS_STATUS_SEL;
    wire [PW-1:0] pre_wd = PW'(WDATA[PEW-1:0]);

    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            join_q    <= 1'b0;
            mode_a_q  <= '0;
            mode_b_q  <= '0;
            ctl_q     <= '0;
            load_a_q  <= '0;
            load_b_q  <= '0;
            match_a_q <= '0;
            match_b_q <= '0;
            pre_a_q   <= '0;
            pre_b_q   <= '0;
            pmr_a_q   <= '0;
            pmr_b_q   <= '0;
            imask_q   <= '0;
            sel_q     <= 1'b0;
        end else if (CE) begin
            if (w_cfg) begin
                join_q   <= WDATA[`CFG_JOIN_BIT];
                mode_a_q <= WDATA[`CFG_MODE_A_LSB +: `CFG_MODE_W];
                mode_b_q <= WDATA[`CFG_MODE_B_LSB +: `CFG_MODE_W];
            end
            if (w_ctl)   ctl_q     <= WDATA[3:0];
            if (w_ld_a)  load_a_q  <= HW'(WDATA);
            if (w_ld_b)  load_b_q  <= HW'(WDATA);
            if (w_mt_a)  match_a_q <= HW'(WDATA);
            if (w_mt_b)  match_b_q <= HW'(WDATA);
            if (w_pr_a)  pre_a_q   <= pre_wd;
            if (w_pr_b)  pre_b_q   <= pre_wd;
            if (w_pm_a)  pmr_a_q   <= pre_wd;
            if (w_pm_b)  pmr_b_q   <= pre_wd;
            if (w_imask) imask_q   <= WDATA[IW-1:0];
            if (w_sel)   sel_q     <= WDATA[0];
        end
    end

    // ------------------------------------------------------------------
    // Halves; joined mode chains both loads into one wide counter
    // ------------------------------------------------------------------
    assign ha.en       = ctl_q[`CTL_EN_A_BIT];
    assign ha.mie      = ctl_q[`CTL_MIE_A_BIT];
    assign ha.mode     = timer_pkg::mode_t'(mode_a_q);
    // Joined count is {second word, first word}; a load write counts at once
    wire          lo_a     = ha.mode == timer_pkg::MODE_ONE_SHOT ||
                             ha.mode == timer_pkg::MODE_PERIODIC;
    wire [HW-1:0] load_a_d = w_ld_a ? HW'(WDATA) : load_a_q;
    wire [HW-1:0] load_b_d = w_ld_b ? HW'(WDATA) : load_b_q;
    wire [EW-1:0] jload    = {PW'(load_b_d), load_a_d};
    wire [EW-1:0] jmatch   = {PW'(match_b_q), match_a_q};
    assign ha.load     = (join_q && lo_a) ? jload[EW-1:PW] : load_a_d;
    assign ha.match    = (join_q && lo_a) ? jmatch[EW-1:PW] : match_a_q;
    assign ha.pre      = !join_q ? pre_a_q : lo_a ? jload[PW-1:0] : PW'(load_b_d);
    assign ha.pmr      = !join_q ? pmr_a_q : lo_a ? jmatch[PW-1:0] : PW'(match_b_q);
    assign ha.load_now = CE && ha.en && (w_ld_a || w_ld_hi);
    assign ha.cap_edge = rise[0];

    assign hb.en       = ctl_q[`CTL_EN_B_BIT] && !join_q;
    assign hb.mie      = ctl_q[`CTL_MIE_B_BIT];
    assign hb.mode     = timer_pkg::mode_t'(mode_b_q);
    assign hb.load     = load_b_d;
    assign hb.match    = match_b_q;
    assign hb.pre      = pre_b_q;
    assign hb.pmr      = pmr_b_q;
    assign hb.load_now = CE && hb.en && w_ld_b;
    assign hb.cap_edge = rise[1];

    timer_half #(.HW(HW), .PW(PW)) u_a (.MCLK(MCLK), .RST_N(RST_N), .CE(CE), .h(ha));
    timer_half #(.HW(HW), .PW(PW)) u_b (.MCLK(MCLK), .RST_N(RST_N), .CE(CE), .h(hb));

    // ------------------------------------------------------------------
    // Interrupt status
    // ------------------------------------------------------------------
    always_comb begin
        iset                   = '0;
        iset[`IRQ_A_TIMEOUT]   = ha.timeout;
        iset[`IRQ_A_CAP_MATCH] = ha.cap_match;
        iset[`IRQ_A_CAP_EVENT] = ha.cap_event;
        iset[`IRQ_RTC_MATCH]   = rise[2];
        iset[`IRQ_B_TIMEOUT]   = hb.timeout;
        iset[`IRQ_B_CAP_MATCH] = hb.cap_match;
        iset[`IRQ_B_CAP_EVENT] = hb.cap_event;
    end
    // Set wins over a clear in the same cycle
    assign ris_d = (ris_q & ~(w_iclr ? WDATA[IW-1:0] : '0)) | iset;

    wire [IW-1:0] mis = ris_q & imask_q;
    wire [IW-1:0] imask_d = w_imask ? WDATA[IW-1:0] : imask_q;

    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            ris_q <= '0;
            IRQ   <= 1'b0;
            PWM_A <= 1'b0;
            PWM_B <= 1'b0;
        end else if (CE) begin
            ris_q <= ris_d;
            IRQ   <= |(ris_d & imask_d);
            PWM_A <= ha.pwm;
            PWM_B <= hb.pwm;
        end
    end

    // ------------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------------
    wire [EW-1:0] va = ha.value;
    wire [31:0]   val_a  = join_q ? 32'(va[HW-1:0]) : 32'(va[EW-1:PW]);
    wire [31:0]   val_b  = join_q ? 32'(va[EW-1:HW]) : 32'(hb.value[EW-1:PW]);
    wire [31:0]   cfg_rd = {21'h0, mode_b_q, 1'b0, mode_a_q, 3'h0, join_q};
    wire [31:0]   st_rd  = 32'(sel_q ? mis : ris_q);
    logic [31:0]  rd_mux;
    always_comb begin
        case (ADDR)
            `OFS_CFG:        rd_mux = cfg_rd;
            `OFS_CTL:        rd_mux = 32'(ctl_q);
            `OFS_LOAD_A:     rd_mux = 32'(load_a_q);
            `OFS_LOAD_B:     rd_mux = 32'(load_b_q);
            `OFS_MATCH_A:    rd_mux = 32'(match_a_q);
            `OFS_MATCH_B:    rd_mux = 32'(match_b_q);
            `OFS_PRE_A:      rd_mux = 32'(pre_a_q);
            `OFS_PRE_B:      rd_mux = 32'(pre_b_q);
            `OFS_PMR_A:      rd_mux = 32'(pmr_a_q);
            `OFS_PMR_B:      rd_mux = 32'(pmr_b_q);
            `OFS_VAL_A:      rd_mux = val_a;
            `OFS_VAL_B:      rd_mux = val_b;
            `OFS_IMASK:      rd_mux = 32'(imask_q);
            `OFS_RIS:        rd_mux = 32'(ris_q);
            `OFS_MIS:        rd_mux = 32'(mis);
            `OFS_STATUS_SEL: rd_mux = st_rd;
            default:         rd_mux = `RESET_VALUE;
        endcase
    end

    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            RDATA <= '0;
        end else if (CE && RD) begin
            RDATA <= rd_mux;
        end
    end
endmodule : timer_load_match_prescale

// ### tb/timer_monitor.sv
// Port-level assertions for the timer pair
`timescale 1ns/1ps
`include "timer_consts.svh"
module timer_monitor #(
    parameter int HW   = 32,
    parameter int PW   = 16,
    parameter bit WIDE = 1'b1
) (
    input wire logic        MCLK,
    input wire logic        RST_N,
    input wire logic        CE,
    input wire logic [7:0]  ADDR,
    input wire logic [31:0] WDATA,
    input wire logic        WR,
    input wire logic        RD,
    input wire logic [31:0] RDATA,
    input wire logic        IRQ,
    input wire logic        PWM_A,
    input wire logic        PWM_B
);
    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    a_reset_clears_out: assert property (@(posedge MCLK) !RST_N && CE |=>
        RDATA == 32'h0 && !IRQ && !PWM_A && !PWM_B) else $error("outputs not cleared by reset");
    a_rdata_stands: assert property (@(posedge MCLK) disable iff (!RST_N)
        !$past(RD) |-> $stable(RDATA)) else $error("read data moved without a read");
    a_unmapped_zero: assert property (@(posedge MCLK) disable iff (!RST_N)
        RD && CE && ADDR > 8'h50 |=> RDATA == 32'h0) else $error("unmapped read not zero");
    a_mask_zero_quiet: assert property (@(posedge MCLK) disable iff (!RST_N)
        WR && CE && ADDR == `OFS_IMASK && WDATA == 32'h0 |=> !IRQ) else $error("irq with empty mask");
    property load_readback;
        logic [31:0] v;
        @(posedge MCLK) disable iff (!RST_N)
        (WR && CE && ADDR == `OFS_LOAD_A, v = WDATA) ##1 (RD && CE && ADDR == `OFS_LOAD_A)
        |=> RDATA == v;
    endproperty
    a_load_readback: assert property (load_readback) else $error("load readback wrong");
    a_pre_width: assert property (@(posedge MCLK) disable iff (!RST_N)
        (WR && CE && ADDR == `OFS_PRE_A) ##1 (RD && CE && ADDR == `OFS_PRE_A)
        |=> RDATA[31:16] == 16'h0) else $error("prescale wider than field");
    property both_write;
        logic [31:0] v;
        @(posedge MCLK) disable iff (!RST_N)
        (WR && CE && ADDR == `OFS_MATCH_BOTH, v = WDATA) ##1 (RD && CE && ADDR == `OFS_MATCH_B)
        |=> RDATA == v;
    endproperty
    a_both_halves: assert property (both_write) else $error("second half missed joint write");
    a_masked_irq: assert property (@(posedge MCLK) disable iff (!RST_N)
        RD && CE && ADDR == `OFS_MIS |=> (|RDATA[10:0]) == $past(IRQ)) else $error("irq disagrees");
    // ------------------------------------------------------------------
    // Coverage
    // ------------------------------------------------------------------
    c_masked_read: cover property (@(posedge MCLK) RD && ADDR == `OFS_MIS && IRQ);
    c_irq_rise: cover property (@(posedge MCLK) $rose(IRQ));
    c_clear: cover property (@(posedge MCLK) WR && ADDR == `OFS_ICLR);
endmodule : timer_monitor
bind timer_load_match_prescale timer_monitor #(.HW(HW), .PW(PW), .WIDE(WIDE)) u_mon (
    .MCLK(MCLK), .RST_N(RST_N), .CE(CE), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
    .RDATA(RDATA), .IRQ(IRQ), .PWM_A(PWM_A), .PWM_B(PWM_B));

// ### tb/timer_load_match_prescale_bench.sv
// Self-checking bench for the timer pair registers and status
`timescale 1ns/1ps
`include "timer_consts.svh"
`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin fails++; \
    $display("Error at %0t: got %h expected %h", $time, got, exp); end end
module timer_load_match_prescale_bench;
    logic        MCLK = 1'b0;
    logic        RST_N = 1'b0;
    logic        CE = 1'b1;
    logic [7:0]  ADDR = 8'h00;
    logic [31:0] WDATA = 32'h0;
    logic        WR = 1'b0;
    logic        RD = 1'b0;
    logic        CAP_A = 1'b0;
    logic        CAP_B = 1'b0;
    logic        RTC_MATCH = 1'b0;
    logic [31:0] RDATA;
    logic        IRQ;
    logic        PWM_A;
    logic        PWM_B;
    logic [31:0] exp_q[$];
    logic [31:0] msk_q[$];
    logic        rd_seen = 1'b0;
    int          fails = 0;
    int          samples_checked = 0;
    int          cycles = 0;
    int          seed = 38;
    logic [31:0] d;
    logic [31:0] e_v;
    logic [31:0] m_v;

    timer_load_match_prescale DUT (.MCLK(MCLK), .RST_N(RST_N), .CE(CE), .ADDR(ADDR),
        .WDATA(WDATA), .WR(WR), .RD(RD), .CAP_A(CAP_A), .CAP_B(CAP_B),
        .RTC_MATCH(RTC_MATCH), .RDATA(RDATA), .IRQ(IRQ), .PWM_A(PWM_A), .PWM_B(PWM_B));

    initial begin
        forever #12.5 MCLK = ~MCLK;
    end

    // ------------------------------------------------------------------
    // Bus tasks
    // ------------------------------------------------------------------
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        ADDR  <= a;
        WDATA <= v;
        WR    <= 1'b1;
        RD    <= 1'b0;
        @(posedge MCLK);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
        exp_q.push_back(e & m);
        msk_q.push_back(m);
        ADDR <= a;
        WR   <= 1'b0;
        RD   <= 1'b1;
        @(posedge MCLK);
    endtask : rd

    task automatic idle(input int n);
        WR <= 1'b0;
        RD <= 1'b0;
        repeat (n) @(posedge MCLK);
    endtask : idle

    task automatic chk_irq(input logic e);
        WR <= 1'b0;
        RD <= 1'b0;
        @(negedge MCLK);
        `CHK(IRQ, e)
        @(posedge MCLK);
    endtask : chk_irq

    task automatic complete_run;
        $display("Comparisons %0d, mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : complete_run

    // ------------------------------------------------------------------
    // Result watcher and timeout
    // ------------------------------------------------------------------
    always @(posedge MCLK) begin
        rd_seen <= RD && RST_N;
        cycles++;
        if (cycles == 5000) begin
            fails++;
            complete_run();
        end
    end

    always @(negedge MCLK) begin
        if (rd_seen) begin
            m_v = msk_q.pop_front();
            e_v = exp_q.pop_front();
            `CHK(RDATA & m_v, e_v)
        end
    end

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        repeat (20) @(posedge MCLK);
        RST_N <= 1'b1;
        @(posedge MCLK);
        for (int i = 0; i < 19; i++) begin
            rd(8'(i * 4), 32'h0, 32'hFFFF_FFFF);
        end
        rd(`OFS_RIS, 32'h0, 32'hFFFF_FFFF);
        rd(8'h7C, 32'h0, 32'hFFFF_FFFF);
        for (int i = 0; i < 4; i++) begin
            d = $random(seed);
            wr(`OFS_LOAD_A, d);
            rd(`OFS_LOAD_A, d, 32'hFFFF_FFFF);
            wr(`OFS_MATCH_BOTH, ~d);
            rd(`OFS_MATCH_B, ~d, 32'hFFFF_FFFF);
            rd(`OFS_MATCH_A, ~d, 32'hFFFF_FFFF);
            wr(`OFS_PRE_A, d);
            rd(`OFS_PRE_A, {16'h0, d[15:0]}, 32'hFFFF_FFFF);
            wr(`OFS_PMR_BOTH, d);
            rd(`OFS_PMR_B, {16'h0, d[15:0]}, 32'hFFFF_FFFF);
        end
        // Running periodic half A takes a new load at once
        wr(`OFS_CFG, 32'h0000_0010);
        wr(`OFS_PRE_A, 32'h0);
        wr(`OFS_LOAD_A, 32'h0000_0100);
        wr(`OFS_CTL, 32'h1);
        idle(5);
        wr(`OFS_LOAD_A, 32'h00F0_0100);
        rd(`OFS_VAL_A, 32'h00F0_0000, 32'hFFFF_F000);
        rd(`OFS_LOAD_A, 32'h00F0_0100, 32'hFFFF_FFFF);
        wr(`OFS_CTL, 32'h0);
        wr(`OFS_IMASK, 32'h0);
        wr(`OFS_ICLR, 32'h7FF);
        rd(`OFS_RIS, 32'h0, 32'hFFFF_FFFF);
        RTC_MATCH <= 1'b1;
        idle(8);
        RTC_MATCH <= 1'b0;
        rd(`OFS_RIS, 32'h8, 32'hFFFF_FFFF);
        rd(`OFS_MIS, 32'h0, 32'hFFFF_FFFF);
        wr(`OFS_STATUS_SEL, 32'h1);
        rd(`OFS_STATUS_SEL, 32'h0, 32'hFFFF_FFFF);
        chk_irq(1'b0);
        wr(`OFS_IMASK, 32'h8);
        idle(1);
        rd(`OFS_MIS, 32'h8, 32'hFFFF_FFFF);
        rd(`OFS_STATUS_SEL, 32'h8, 32'hFFFF_FFFF);
        chk_irq(1'b1);
        wr(`OFS_ICLR, 32'h1);
        rd(`OFS_RIS, 32'h8, 32'hFFFF_FFFF);
        wr(`OFS_ICLR, 32'h8);
        idle(1);
        rd(`OFS_RIS, 32'h0, 32'hFFFF_FFFF);
        chk_irq(1'b0);
        // One-shot half A times out and raises its own bit
        wr(`OFS_CFG, 32'h0);
        wr(`OFS_PRE_A, 32'h4);
        wr(`OFS_IMASK, 32'h1);
        wr(`OFS_CTL, 32'h1);
        wr(`OFS_LOAD_A, 32'h0);
        idle(1);
        for (int i = 0; i < 60 && IRQ !== 1'b1; i++) begin
            @(posedge MCLK);
        end
        rd(`OFS_RIS, 32'h1, 32'h0000_0701);
        chk_irq(1'b1);
        // Joined pair reloads the wide count from both load words
        wr(`OFS_CTL, 32'h0);
        wr(`OFS_CFG, 32'h0000_0011);
        wr(`OFS_LOAD_B, 32'h0000_0012);
        wr(`OFS_CTL, 32'h1);
        wr(`OFS_LOAD_A, 32'h3400_0000);
        rd(`OFS_VAL_B, 32'h0000_0012, 32'hFFFF_FFFF);
        rd(`OFS_VAL_A, 32'h33FF_0000, 32'hFFFF_0000);
        idle(3);
        complete_run();
    end
endmodule : timer_load_match_prescale_bench
